// file: swd_pkg.sv
/*
  Constants, field layout and phase type for the single wire debug controller.
  Assumes the debug clock is clk_in; every timing count here is in debug clock cycles.
*/
package swd_pkg;
  localparam logic [4:0] RX_SAMPLE = 5'h0A;
  localparam logic [4:0] ONE_PULSE = 5'h07;
  localparam logic [4:0] ZERO_LOW = 5'h0D;
  localparam logic [4:0] BIT_END = 5'h0F;
  localparam logic [9:0] TIMEOUT = 10'h200;
  localparam logic [7:0] SYNC_MIN_LOW = 8'h80;
  localparam logic [7:0] SYNC_GAP = 8'h10;
  localparam logic [7:0] SYNC_PULSE = 8'h80;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [7:0] CMD_BGND = 8'h90;
  localparam logic [7:0] CMD_RD_STAT = 8'hE4;
  localparam logic [7:0] CMD_WR_CTRL = 8'hC4;
  localparam logic [7:0] CMD_RD_BYTE = 8'hE0;
  localparam logic [7:0] CMD_RD_BYTE_WS = 8'hE1;
  localparam logic [7:0] CMD_RD_LAST = 8'hE8;
  localparam logic [7:0] CMD_WR_BYTE = 8'hC0;
  localparam logic [7:0] CMD_WR_BYTE_WS = 8'hC1;
  localparam logic [7:0] CMD_RD_BKPT = 8'hE2;
  localparam logic [7:0] CMD_WR_BKPT = 8'hC2;
  localparam logic [7:0] CMD_GO = 8'h08;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_TAGGO = 8'h18;
  localparam logic [4:0] CMD_RD_REG_HI = 5'h0D;
  localparam logic [4:0] CMD_WR_REG_HI = 5'h09;
  localparam int CTL_ENABLE = 7;
  localparam int CTL_BGND = 6;
  localparam int CTL_BKPTEN = 5;
  localparam int CTL_CLKSW = 3;
  localparam logic [15:0] BKPT_RESET = 16'hFFFF;
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DATA, ST_MEM, ST_TX} phase_t;
endpackage

// file: line_sync.sv
/*
  Two flip-flop synchroniser for the debug line input.
  Assumes d_in is asynchronous to clk_in; no reset so the level is seen during reset.
*/
`timescale 1ns/1ps
`default_nettype none
module line_sync (
  input wire logic clk_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_r;

  always_ff @(posedge clk_in) begin
    meta_r <= d_in;
    q_out <= meta_r;
  end
endmodule
`default_nettype wire

// file: single_wire_debug_controller.sv
/*
  Target side single wire debug controller: bit engine, command decoder,
  status and control bits, breakpoint, speed probe answer and boot mode strap.
  Assumes clk_in is the debug clock, memory answers with mem_ack_in before the
  host's 16 cycle delay ends, and reg_rdata_in follows reg_sel_out at once.
*/
// Function
// - Commands and data travel most significant bit first both ways.
// - The debug line is sampled during reset to choose the boot mode.
// - A line held high by the pullup selects normal start after reset.
// - A long host low pulse gets a timed low answer pulse back.
// - Background class commands act only while the CPU is halted.
// - Non-intrusive commands act at any time, even while running.
// - Non-intrusive commands reach memory and the controller's own registers.
// - Halted commands access CPU registers, single step and resume.
// - The enter-background command can wake the CPU from stop or wait.
// - The oscillator keeps running in stop while the controller is enabled.
// - The liveness watchdog is held off while the CPU is halted.
// - The controller holds one hardware address breakpoint.
// - Controller registers are reached only by line commands, not memory.
// - Brief driven high pulses speed rising edges without drive conflicts.
// - The line answers without needing a reset first.
// - Debug clock is the bus clock or the low frequency generator clock.
// - 512 cycles without a falling edge abort the command in progress.
// - Host bits are sampled ten cycles after the perceived falling edge.
// - A sent one is a high pulse seven cycles after the bit start.
// - A sent zero is held low 13 cycles, then briefly driven high.
`timescale 1ns/1ps
`default_nettype none
module single_wire_debug_controller
  import swd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_out,
  input wire logic cpu_bgnd_in,
  input wire logic [15:0] bus_addr_in,
  input wire logic bus_fetch_in,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  input wire logic mem_ack_in,
  output logic reg_req_out,
  output logic reg_we_out,
  output logic [2:0] reg_sel_out,
  output logic [15:0] reg_wdata_out,
  input wire logic [15:0] reg_rdata_in,
  output logic bgnd_req_out,
  output logic go_req_out,
  output logic step_req_out,
  output logic bkpt_hit_out,
  output logic boot_bgnd_out,
  output logic osc_keep_out,
  output logic wdog_hold_out,
  output logic clk_sel_out
);
  logic line_s;
  logic line_d_r;
  logic fall;
  logic bit_act_r;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic tx_act_r;
  logic tx_bit_r;
  logic [9:0] idle_r;
  logic timeout;
  logic [7:0] low_r;
  logic sync_pend_r;
  logic sync_start;
  logic [8:0] sync_r;
  logic sync_drive;
  logic rx_evt;
  logic tx_evt;
  logic [15:0] rx_word;
  phase_t state_r;
  logic [7:0] cmd_r;
  logic [15:0] rx_sr_r;
  logic [4:0] rx_left_r;
  logic [15:0] tx_sr_r;
  logic [4:0] tx_left_r;
  logic [7:0] last_r;
  logic [7:0] status;
  logic enbdm_r;
  logic bkpten_r;
  logic [15:0] bkpt_r;
  logic line_out_nxt;
  logic line_oe_nxt;

  // The line passes two flip-flops before the edge detector sees it.
  line_sync u_sync (
    .clk_in(clk_in),
    .d_in(line_in),
    .q_out(line_s)
  );

  // The device's own speed probe pulse must not look like a host bit start.
  assign fall = line_d_r && !line_s && !sync_drive;
  assign cnt_nxt = fall ? 5'h00 : (cnt_r + 5'h01);
  assign timeout = (idle_r == TIMEOUT - 10'h001);
  assign sync_start = sync_pend_r && line_s;
  assign sync_drive = (sync_r != 9'h000);
  assign rx_evt = bit_act_r && !tx_act_r && (cnt_r == RX_SAMPLE) && (state_r != ST_TX);
  assign tx_evt = bit_act_r && tx_act_r && (cnt_r == ZERO_LOW);
  assign rx_word = {rx_sr_r[14:0], line_s};
  assign status = {enbdm_r, cpu_bgnd_in, bkpten_r, 1'b0, clk_sel_out, 3'b000};

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      line_d_r <= 1'b1;
    end else begin
      line_d_r <= line_s;
    end
  end

  // Bit timer counts from the perceived start of each host bit.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || sync_start) begin
      bit_act_r <= 1'b0;
      cnt_r <= 5'h00;
      tx_act_r <= 1'b0;
      tx_bit_r <= 1'b0;
    end else if (fall) begin
      bit_act_r <= 1'b1;
      cnt_r <= cnt_nxt;
      tx_act_r <= (state_r == ST_TX);
      tx_bit_r <= tx_sr_r[15];
    end else if (bit_act_r) begin
      cnt_r <= cnt_nxt;
      bit_act_r <= (cnt_r != BIT_END);
    end
  end

  // Cycles since the last host falling edge, and length of the current low level.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || fall || timeout) begin
      idle_r <= 10'h000;
    end else begin
      idle_r <= idle_r + 10'h001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      low_r <= 8'h00;
      sync_pend_r <= 1'b0;
    end else if (line_s || sync_drive) begin
      low_r <= 8'h00;
      sync_pend_r <= 1'b0;
    end else if (low_r != SYNC_MIN_LOW) begin
      low_r <= low_r + 8'h01;
    end else begin
      sync_pend_r <= 1'b1;
    end
  end

  // Speed probe answer: a gap, a low pulse, then one speedup cycle.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sync_r <= 9'h000;
    end else if (sync_start) begin
      sync_r <= {1'b0, SYNC_GAP} + {1'b0, SYNC_PULSE} + 9'h001;
    end else if (sync_drive) begin
      sync_r <= sync_r - 9'h001;
    end
  end

  // Line drive, registered so it lines up with cnt_r.
  always_comb begin
    line_out_nxt = 1'b0;
    line_oe_nxt = 1'b0;
    if (sync_r > 9'h001 && sync_r <= {1'b0, SYNC_PULSE} + 9'h001) begin
      line_oe_nxt = 1'b1;
    end else if (sync_r == 9'h001) begin
      line_oe_nxt = 1'b1;
      line_out_nxt = 1'b1;
    end else if (fall && state_r == ST_TX && !tx_sr_r[15]) begin
      line_oe_nxt = 1'b1;
    end else if (bit_act_r && tx_act_r && !fall) begin
      if (!tx_bit_r && cnt_nxt < ZERO_LOW) begin
        line_oe_nxt = 1'b1;
      end else if (!tx_bit_r && cnt_nxt == ZERO_LOW) begin
        line_oe_nxt = 1'b1;
        line_out_nxt = 1'b1;
      end else if (tx_bit_r && cnt_nxt == ONE_PULSE) begin
        line_oe_nxt = 1'b1;
        line_out_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      line_out <= 1'b0;
      line_oe_out <= 1'b0;
    end else begin
      line_out <= line_out_nxt;
      line_oe_out <= line_oe_nxt;
    end
  end

  // Command sequencer; held in ST_CMD with its registers cleared while rst_b_in is low.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_r <= ST_CMD;
      cmd_r <= 8'h00;
      rx_sr_r <= 16'h0000;
      rx_left_r <= BYTE_BITS;
      tx_sr_r <= 16'h0000;
      tx_left_r <= 5'h00;
      last_r <= 8'h00;
      enbdm_r <= 1'b0;
      bkpten_r <= 1'b0;
      clk_sel_out <= 1'b0;
      bkpt_r <= BKPT_RESET;
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_addr_out <= 16'h0000;
      mem_wdata_out <= 8'h00;
      reg_req_out <= 1'b0;
      reg_we_out <= 1'b0;
      reg_sel_out <= 3'h0;
      reg_wdata_out <= 16'h0000;
      bgnd_req_out <= 1'b0;
      go_req_out <= 1'b0;
      step_req_out <= 1'b0;
    end else begin
      reg_req_out <= 1'b0;
      bgnd_req_out <= 1'b0;
      go_req_out <= 1'b0;
      step_req_out <= 1'b0;
      if (timeout || sync_start) begin
        state_r <= ST_CMD;
        rx_left_r <= BYTE_BITS;
        tx_left_r <= 5'h00;
      end else if (rx_evt) begin
        rx_sr_r <= rx_word;
        rx_left_r <= rx_left_r - 5'h01;
        if (rx_left_r == 5'h01) begin
          rx_left_r <= BYTE_BITS;
          if (state_r == ST_CMD) begin
            cmd_r <= rx_word[7:0];
            state_r <= ST_CMD;
            unique case (rx_word[7:0])
              CMD_BGND: bgnd_req_out <= enbdm_r;
              CMD_RD_STAT: begin
                tx_sr_r <= {status, 8'h00};
                tx_left_r <= BYTE_BITS;
                state_r <= ST_TX;
              end
              CMD_WR_CTRL: state_r <= ST_DATA;
              CMD_RD_BYTE, CMD_RD_BYTE_WS, CMD_WR_BYTE, CMD_WR_BYTE_WS: begin
                rx_left_r <= WORD_BITS;
                state_r <= ST_ADDR;
              end
              CMD_RD_LAST: begin
                tx_sr_r <= {status, last_r};
                tx_left_r <= WORD_BITS;
                state_r <= ST_TX;
              end
              CMD_RD_BKPT: begin
                tx_sr_r <= bkpt_r;
                tx_left_r <= WORD_BITS;
                state_r <= ST_TX;
              end
              CMD_WR_BKPT: begin
                rx_left_r <= WORD_BITS;
                state_r <= ST_DATA;
              end
              CMD_GO, CMD_TAGGO: go_req_out <= cpu_bgnd_in;
              CMD_STEP: step_req_out <= cpu_bgnd_in;
              default: begin
                if (cpu_bgnd_in && rx_word[7:3] == CMD_RD_REG_HI) begin
                  reg_sel_out <= rx_word[2:0];
                  reg_we_out <= 1'b0;
                  reg_req_out <= 1'b1;
                  state_r <= ST_MEM;
                end else if (cpu_bgnd_in && rx_word[7:3] == CMD_WR_REG_HI) begin
                  reg_sel_out <= rx_word[2:0];
                  rx_left_r <= WORD_BITS;
                  state_r <= ST_DATA;
                end
              end
            endcase
          end else if (state_r == ST_ADDR) begin
            mem_addr_out <= rx_word;
            if (cmd_r == CMD_WR_BYTE || cmd_r == CMD_WR_BYTE_WS) begin
              state_r <= ST_DATA;
            end else begin
              mem_we_out <= 1'b0;
              mem_req_out <= 1'b1;
              state_r <= ST_MEM;
            end
          end else begin
            state_r <= ST_CMD;
            if (cmd_r == CMD_WR_CTRL) begin
              enbdm_r <= rx_word[CTL_ENABLE];
              bkpten_r <= rx_word[CTL_BKPTEN];
              clk_sel_out <= rx_word[CTL_CLKSW];
            end else if (cmd_r == CMD_WR_BKPT) begin
              bkpt_r <= rx_word;
            end else if (cmd_r == CMD_WR_BYTE || cmd_r == CMD_WR_BYTE_WS) begin
              mem_wdata_out <= rx_word[7:0];
              mem_we_out <= 1'b1;
              mem_req_out <= 1'b1;
              state_r <= ST_MEM;
            end else begin
              reg_wdata_out <= rx_word;
              reg_we_out <= 1'b1;
              reg_req_out <= 1'b1;
            end
          end
        end
      end else if (state_r == ST_MEM) begin
        if (cmd_r[7:3] == CMD_RD_REG_HI) begin
          tx_sr_r <= reg_rdata_in;
          tx_left_r <= WORD_BITS;
          state_r <= ST_TX;
        end else if (mem_ack_in) begin
          mem_req_out <= 1'b0;
          state_r <= ST_CMD;
          if (!mem_we_out) begin
            last_r <= mem_rdata_in;
            tx_sr_r <= (cmd_r == CMD_RD_BYTE_WS) ? {status, mem_rdata_in}
                                                 : {mem_rdata_in, 8'h00};
            tx_left_r <= (cmd_r == CMD_RD_BYTE_WS) ? WORD_BITS : BYTE_BITS;
            state_r <= ST_TX;
          end else if (cmd_r == CMD_WR_BYTE_WS) begin
            tx_sr_r <= {status, 8'h00};
            tx_left_r <= BYTE_BITS;
            state_r <= ST_TX;
          end
        end
      end else if (tx_evt && state_r == ST_TX) begin
        tx_sr_r <= {tx_sr_r[14:0], 1'b0};
        tx_left_r <= tx_left_r - 5'h01;
        if (tx_left_r == 5'h01) begin
          state_r <= ST_CMD;
        end
      end
    end
  end

  // Boot strap: low line during reset means start halted.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      boot_bgnd_out <= !line_s;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      bkpt_hit_out <= 1'b0;
      osc_keep_out <= 1'b0;
      wdog_hold_out <= 1'b0;
    end else begin
      bkpt_hit_out <= bkpten_r && bus_fetch_in && (bus_addr_in == bkpt_r);
      osc_keep_out <= enbdm_r;
      wdog_hold_out <= cpu_bgnd_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  a_rx_sample_bit: assert property (rx_evt |=> rx_sr_r[0] == $past(line_s))
    else $error("host bit not shifted in at sample point");
  a_zero_low_end: assert property ($rose(tx_act_r) && !tx_bit_r |->
    (line_oe_out && !line_out)[*8] ##1 (line_oe_out && !line_out)[*5]
    ##1 (line_oe_out && line_out))
    else $error("sent zero not held low thirteen cycles then pulsed");
  a_one_pulse_time: assert property (bit_act_r && tx_act_r && tx_bit_r && cnt_r == 5'h06
    |=> line_oe_out && line_out ##1 !line_oe_out)
    else $error("speedup pulse for a one misplaced");
  a_rx_no_drive: assert property (!tx_act_r && !sync_drive && !$past(sync_drive)
    && !$past(fall) |-> !line_oe_out)
    else $error("device drives line while host owns it");
  a_timeout_abort: assert property (timeout |=> state_r == ST_CMD && idle_r == 10'h000)
    else $error("timeout did not abort command");
  a_go_gated: assert property (go_req_out || step_req_out |-> $past(cpu_bgnd_in))
    else $error("resume or step issued while running");
  a_wdog_follow: assert property (cpu_bgnd_in ##1 cpu_bgnd_in |-> wdog_hold_out)
    else $error("watchdog not held in background");
  a_bkpt_match: assert property (bkpt_hit_out |->
    $past(bus_fetch_in && bkpten_r && bus_addr_in == bkpt_r))
    else $error("breakpoint hit without matching fetch");
  a_sync_answer: assert property (sync_start |-> ##18 (line_oe_out && !line_out))
    else $error("speed probe answer pulse missing");
endmodule
`default_nettype wire

// file: debug_pod.sv
/*
  Behavioural debug pod that acts as host on the single wire debug line.
  Assumes the bench resolves the wire from both drivers and the pullup.
*/
`timescale 1ns/1ps
`default_nettype none
module debug_pod (
  input wire logic clk_in,
  input wire logic line_in,
  output logic drv_oe_out,
  output logic drv_out
);
  initial begin
    drv_oe_out = 1'b0;
    drv_out = 1'b1;
  end
  // Sends one bit: low for 3 or 16 cycles, a one cycle high push, then release.
  task automatic tx_bit(input logic b);
    @(negedge clk_in);
    drv_oe_out = 1'b1;
    drv_out = 1'b0;
    repeat (b ? 3 : 16) @(negedge clk_in);
    drv_out = 1'b1;
    @(negedge clk_in);
    drv_oe_out = 1'b0;
    repeat (b ? 15 : 2) @(negedge clk_in);
  endtask
  // Starts a bit, lets go after three cycles and samples the wire later.
  // Holding low until the device has taken over a zero avoids a false edge.
  task automatic rx_bit(output logic b);
    @(negedge clk_in);
    drv_oe_out = 1'b1;
    drv_out = 1'b0;
    repeat (3) @(negedge clk_in);
    drv_oe_out = 1'b0;
    repeat (8) @(negedge clk_in);
    b = line_in;
    repeat (8) @(negedge clk_in);
  endtask
  task automatic tx8(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) tx_bit(v[i]);
  endtask
  task automatic tx16(input logic [15:0] v);
    tx8(v[15:8]);
    tx8(v[7:0]);
  endtask
  task automatic rx8(output logic [7:0] v);
    logic b;
    for (int i = 0; i < 8; i++) begin
      rx_bit(b);
      v = {v[6:0], b};
    end
  endtask
  task automatic rx16(output logic [15:0] v);
    rx8(v[15:8]);
    rx8(v[7:0]);
  endtask
  task automatic wait_d();
    repeat (16) @(negedge clk_in);
  endtask
  // Long low request, then waits out the answer pulse.
  task automatic sync_req();
    @(negedge clk_in);
    drv_oe_out = 1'b1;
    drv_out = 1'b0;
    repeat (140) @(negedge clk_in);
    drv_out = 1'b1;
    @(negedge clk_in);
    drv_oe_out = 1'b0;
    repeat (180) @(negedge clk_in);
  endtask
  task automatic park(input logic low);
    @(negedge clk_in);
    drv_oe_out = low;
    drv_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb_single_wire_debug_controller.sv
/*
  Self-checking bench for the single wire debug controller.
  Assumes a pullup on the wire and a memory that answers one cycle after a request.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_single_wire_debug_controller
  import swd_pkg::*;
;
  typedef struct packed {logic [7:0] ctl; logic halt; logic [7:0] stat;} row_t;
  logic clk_in = 1'b0;
  logic rst_b_in, cpu_bgnd_in, bus_fetch_in;
  logic [15:0] bus_addr_in, reg_rdata_in;
  logic [7:0] mem_rdata_in;
  logic mem_ack_in, mem_busy = 1'b0;
  logic line_out, line_oe_out, pod_oe, pod_drv, wire_lvl, mem_req_out, mem_we_out;
  logic reg_req_out, reg_we_out, bgnd_req_out, go_req_out, step_req_out, bkpt_hit_out;
  logic boot_bgnd_out, osc_keep_out, wdog_hold_out, clk_sel_out, seen_we, r_we;
  logic [15:0] mem_addr_out, reg_wdata_out, seen_addr, r_wd, v16;
  logic [7:0] mem_wdata_out, seen_wd, v8;
  logic [2:0] reg_sel_out, r_sel;
  int num_errors = 0, num_checks = 0, go_n = 0, step_n = 0, bg_n = 0, run = 0, last_run = 0;
  row_t rows [4] = '{'{8'h80, 1'b0, 8'h80}, '{8'h88, 1'b1, 8'hC8},
                     '{8'hA0, 1'b0, 8'hA0}, '{8'h08, 1'b1, 8'h48}};
  assign wire_lvl = line_oe_out ? line_out : (pod_oe ? pod_drv : 1'b1);
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  debug_pod debug_pod_i (.clk_in(clk_in), .line_in(wire_lvl), .drv_oe_out(pod_oe),
    .drv_out(pod_drv));
  single_wire_debug_controller single_wire_debug_controller_i (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .line_in(wire_lvl), .line_out(line_out), .line_oe_out(line_oe_out),
    .cpu_bgnd_in(cpu_bgnd_in), .bus_addr_in(bus_addr_in), .bus_fetch_in(bus_fetch_in),
    .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in),
    .reg_req_out(reg_req_out), .reg_we_out(reg_we_out), .reg_sel_out(reg_sel_out),
    .reg_wdata_out(reg_wdata_out), .reg_rdata_in(reg_rdata_in), .bgnd_req_out(bgnd_req_out),
    .go_req_out(go_req_out), .step_req_out(step_req_out), .bkpt_hit_out(bkpt_hit_out),
    .boot_bgnd_out(boot_bgnd_out), .osc_keep_out(osc_keep_out),
    .wdog_hold_out(wdog_hold_out), .clk_sel_out(clk_sel_out));
  // Memory answers each request once and records what was asked.
  always @(negedge clk_in) begin
    mem_ack_in <= 1'b0;
    if (mem_req_out === 1'b1 && !mem_ack_in && !mem_busy) begin
      mem_ack_in <= 1'b1;
      mem_rdata_in <= mem_addr_out[7:0] ^ 8'h93;
      mem_busy <= 1'b1;
      seen_addr <= mem_addr_out;
      seen_we <= mem_we_out;
      seen_wd <= mem_wdata_out;
    end
    if (mem_req_out === 1'b0) mem_busy <= 1'b0;
  end
  // Pulse counters, register access capture and device low run length.
  always @(posedge clk_in) begin
    if (go_req_out === 1'b1) go_n++;
    if (step_req_out === 1'b1) step_n++;
    if (bgnd_req_out === 1'b1) bg_n++;
    if (reg_req_out === 1'b1) begin
      r_sel <= reg_sel_out;
      r_we <= reg_we_out;
      r_wd <= reg_wdata_out;
    end
    if (line_oe_out === 1'b1 && line_out === 1'b0) run <= run + 1;
    else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_in);
    num_errors++;
    conclude();
  end
  initial begin
    rst_b_in = 1'b0;
    cpu_bgnd_in = 1'b0;
    bus_fetch_in = 1'b0;
    bus_addr_in = 16'h0000;
    reg_rdata_in = 16'hC3A5;
    repeat (8) @(negedge clk_in);
    check("boot idle", 16'(boot_bgnd_out), 16'h0000);
    check("osc reset", 16'(osc_keep_out), 16'h0000);
    rst_b_in = 1'b1;
    end_test("reset");
    for (int k = 0; k < 4; k++) begin
      cpu_bgnd_in = rows[k].halt;
      debug_pod_i.tx8(CMD_WR_CTRL);
      debug_pod_i.tx8(rows[k].ctl);
      debug_pod_i.wait_d();
      debug_pod_i.tx8(CMD_RD_STAT);
      debug_pod_i.rx8(v8);
      check("status", 16'(v8), 16'(rows[k].stat));
      check("osc keep", 16'(osc_keep_out), 16'(rows[k].ctl[7]));
      check("clk sel", 16'(clk_sel_out), 16'(rows[k].ctl[3]));
      check("wdog hold", 16'(wdog_hold_out), 16'(rows[k].halt));
    end
    check("zero low", 16'(last_run), 16'd13);
    end_test("control rows");
    cpu_bgnd_in = 1'b0;
    debug_pod_i.tx8(CMD_WR_CTRL);
    for (int k = 0; k < 3; k++) debug_pod_i.tx_bit(1'b1);
    repeat (600) @(negedge clk_in);
    debug_pod_i.tx8(CMD_RD_STAT);
    debug_pod_i.rx8(v8);
    check("after abort", 16'(v8), 16'h0008);
    end_test("timeout");
    debug_pod_i.tx8(CMD_RD_BYTE);
    debug_pod_i.tx16(16'h1234);
    debug_pod_i.wait_d();
    debug_pod_i.rx8(v8);
    check("read data", 16'(v8), 16'h00A7);
    check("read addr", seen_addr, 16'h1234);
    check("read we", 16'(seen_we), 16'h0000);
    debug_pod_i.tx8(CMD_WR_BYTE);
    debug_pod_i.tx16(16'h0F0F);
    debug_pod_i.tx8(8'h96);
    debug_pod_i.wait_d();
    check("write addr", seen_addr, 16'h0F0F);
    check("write data", 16'(seen_wd), 16'h0096);
    check("write we", 16'(seen_we), 16'h0001);
    end_test("memory");
    debug_pod_i.tx8(CMD_WR_CTRL);
    debug_pod_i.tx8(8'hA0);
    debug_pod_i.tx8(CMD_WR_BKPT);
    debug_pod_i.tx16(16'h3C5A);
    debug_pod_i.tx8(CMD_RD_BKPT);
    debug_pod_i.rx16(v16);
    check("bkpt read", v16, 16'h3C5A);
    bus_addr_in = 16'h3C5A;
    bus_fetch_in = 1'b1;
    @(negedge clk_in);
    check("bkpt hit", 16'(bkpt_hit_out), 16'h0001);
    bus_fetch_in = 1'b0;
    end_test("breakpoint");
    for (int h = 0; h < 2; h++) begin
      cpu_bgnd_in = h[0];
      debug_pod_i.tx8(CMD_GO);
      debug_pod_i.wait_d();
      debug_pod_i.tx8(CMD_STEP);
      debug_pod_i.wait_d();
      debug_pod_i.tx8(CMD_TAGGO);
      debug_pod_i.wait_d();
      check("go count", 16'(go_n), 16'(2 * h));
      check("step count", 16'(step_n), 16'(h));
    end
    cpu_bgnd_in = 1'b0;
    debug_pod_i.tx8(CMD_BGND);
    debug_pod_i.wait_d();
    check("bgnd count", 16'(bg_n), 16'h0001);
    end_test("run control");
    cpu_bgnd_in = 1'b1;
    debug_pod_i.tx8({CMD_WR_REG_HI, 3'h3});
    debug_pod_i.tx16(16'h1234);
    debug_pod_i.wait_d();
    check("reg wsel", 16'(r_sel), 16'h0003);
    check("reg we", 16'(r_we), 16'h0001);
    check("reg wdata", r_wd, 16'h1234);
    debug_pod_i.tx8({CMD_RD_REG_HI, 3'h5});
    debug_pod_i.wait_d();
    debug_pod_i.rx16(v16);
    check("reg rdata", v16, 16'hC3A5);
    check("reg rsel", 16'(r_sel), 16'h0005);
    end_test("cpu registers");
    debug_pod_i.sync_req();
    check("sync low", 16'(last_run), 16'd128);
    debug_pod_i.tx8(CMD_RD_STAT);
    debug_pod_i.rx8(v8);
    check("after probe", 16'(v8), 16'h00E0);
    end_test("speed probe");
    debug_pod_i.park(1'b1);
    rst_b_in = 1'b0;
    repeat (8) @(negedge clk_in);
    check("boot halted", 16'(boot_bgnd_out), 16'h0001);
    end_test("boot strap");
    conclude();
  end
endmodule
`default_nettype wire
